// *** scpb_builder.v ***
// Source capabilities object list builder and sender
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "scpb_consts.vh"

module scpb_builder #(
  parameter NEXTRA    = 6,
  parameter TOFF_CYC  = `SCPB_TOFF_CYC,
  parameter [4:0] FLAGS_STRAP = `SCPB_FLAGS_RESET
) (
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  input  wire        ce,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Received message events
  input  wire        rx_get_src_cap,
  input  wire        rx_get_snk_cap,
  input  wire        rx_src_cap_eop,
  input  wire        rx_src_cap_solicited,
  input  wire        rx_request,
  input  wire [9:0]  rx_req_op,
  input  wire [9:0]  rx_req_max,
  input  wire [2:0]  rx_req_pos,
  input  wire        rx_req_giveback,
  // Transmit stream
  output reg         tx_start,
  output reg  [3:0]  tx_msg_type,
  output reg  [2:0]  tx_nobj,
  output reg         tx_obj_valid,
  output reg  [31:0] tx_obj,
  output reg         tx_last,
  input  wire        tx_ready,
  // Policy outputs
  output reg         tx_wait,
  output reg         tx_gotomin,
  output reg         vbus_off
);

  // Register map, index on reg_addr:
  //   0 control: role, VCONN-only, no offer, Type-A, send, power recovered
  //   1 flag bits for the first object, read only
  //   2 count of extra objects, clipped to six
  //   3 entry voltage, 4 entry current, 5 entry peak code; entry in bits 12..10
  //   6 entry that carries the reserve
  //   7 reserve: bit 16 low releases, bit 17 marks a loan
  //   8 status, read only
  //   9 current of the first object
  // Writes to unmapped indices are dropped and reads return zero.
  // Role and no-offer bits take effect at the next message; role and Type-A bits gate the back-power guard from the next cycle.

  localparam ST_IDLE = 2'h0;
  localparam ST_HDR  = 2'h1;
  localparam ST_OBJ  = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Configuration storage
  reg  [5:0]  ctrl_q;
  reg  [4:0]  flags_q;
  reg  [2:0]  nextra_q;
  reg  [9:0]  base_i_q;
  reg  [9:0]  pv_q [0:NEXTRA-1];
  reg  [9:0]  pi_q [0:NEXTRA-1];
  reg  [1:0]  pk_q [0:NEXTRA-1];
  reg  [2:0]  sel_q;
  reg  [9:0]  reserve_q;
  reg         res_alloc_q;
  reg         res_loan_q;
  reg         pend_src_q;
  reg         pend_snk_q;
  reg         pend_qry_q;
  reg  [1:0]  st_q;
  reg  [2:0]  idx_q;
  reg         snk_q;
  reg  [31:0] toff_cnt_q;
  reg         toff_run_q;
  integer     k;

  // Fixed object assembly
  function [31:0] scpb_fixed;
    input [4:0] flg;
    input [1:0] pk;
    input [9:0] volt;
    input [9:0] curr;
    begin
      scpb_fixed = {`SCPB_TYPE_FIXED, flg, 3'h0, pk, volt, curr};
    end
  endfunction

  // Entry index carried in the upper write bits
  function scpb_entry_ok;
    input [31:0] wdata;
    begin
      scpb_entry_ok = (wdata[13:10] < NEXTRA);
    end
  endfunction

  // Current field clips at all ones rather than wrapping
  function [9:0] scpb_add_sat;
    input [9:0]  a;
    input [9:0]  b;
    reg   [10:0] sum;
    begin
      sum          = {1'b0, a} + {1'b0, b};
      scpb_add_sat = sum[10] ? 10'h3FF : sum[9:0];
    end
  endfunction

  // A second entry at a voltage already listed would give two objects for it
  function scpb_dup_volt;
    input [9:0] volt;
    input [2:0] ent;
    integer     e;
    begin
      scpb_dup_volt = (volt == `SCPB_VSAFE5V_CODE);
      for (e = 0; e < NEXTRA; e = e + 1)
        if (e != ent && pv_q[e] == volt)
          scpb_dup_volt = 1'b1;
    end
  endfunction

  wire        no_cap  = ctrl_q[`SCPB_CTRL_NOCAP] | ctrl_q[`SCPB_CTRL_VCONN];
  wire [9:0]  i5      = no_cap ? 10'h000 : base_i_q;
  wire [2:0]  nsend   = snk_q ? 3'h1 : (3'h1 + nextra_q);
  wire [2:0]  eidx    = idx_q - 3'h1;
  // Reserve is shown by adding it to the current of the chosen object
  wire [9:0]  res_add = res_alloc_q ? reserve_q : 10'h000;
  wire [9:0]  cur_sat = scpb_add_sat(pi_q[eidx], res_add);
  reg  [31:0] obj_w;
  always @* begin
    obj_w = 32'h0000_0000;
    if (idx_q == 3'h0) begin
      obj_w = scpb_fixed(flags_q, 2'h0, `SCPB_VSAFE5V_CODE, i5);
    end else if (eidx < NEXTRA) begin
      if (eidx == sel_q)
        obj_w = scpb_fixed(5'h00, pk_q[eidx], pv_q[eidx], cur_sat);
      else
        obj_w = scpb_fixed(5'h00, pk_q[eidx], pv_q[eidx], pi_q[eidx]);
    end
  end
  wire [9:0]  req_res = (rx_req_max > rx_req_op) ? (rx_req_max - rx_req_op) : 10'h000;
  wire        ws      = ce & reg_wr;
  // Queries are answered in any role; adverts only in the source role
  wire        take    = (st_q == ST_IDLE) & tx_ready &
                        (pend_snk_q | (pend_src_q & ctrl_q[`SCPB_CTRL_SRC]) | pend_qry_q);

  ////////////////////////////////////////////////////////////////////////
  // Register writes, reserve tracking, pending sends
  always @(posedge clk) begin
    if (!nrst) begin
      ctrl_q      <= 6'h00;
      flags_q     <= FLAGS_STRAP;
      nextra_q    <= 3'h0;
      base_i_q    <= 10'h000;
      sel_q       <= 3'h0;
      reserve_q   <= 10'h000;
      res_alloc_q <= 1'b0;
      res_loan_q  <= 1'b0;
      pend_src_q  <= 1'b0;
      pend_snk_q  <= 1'b0;
      pend_qry_q  <= 1'b0;
      tx_wait     <= 1'b0;
      tx_gotomin  <= 1'b0;
      for (k = 0; k < NEXTRA; k = k + 1) begin
        pv_q[k] <= 10'h000;
        pi_q[k] <= 10'h000;
        pk_q[k] <= 2'h0;
      end
    end else if (ce) begin
      tx_wait    <= 1'b0;
      tx_gotomin <= 1'b0;
      // Cleared first so that an event in the same cycle re-arms the flag
      if (take) begin
        if (pend_snk_q) begin
          pend_snk_q <= 1'b0;
        end else begin
          pend_src_q <= 1'b0;
          pend_qry_q <= 1'b0;
        end
      end
      if (ws) begin
        case (reg_addr)
          `SCPB_REG_CTRL: begin
            ctrl_q     <= {1'b0, reg_wdata[4:0]} & 6'h0F;
            pend_src_q <= 1'b1;
            if (reg_wdata[`SCPB_CTRL_GOTOMIN] && res_loan_q) begin
              res_loan_q <= 1'b0;
              pend_src_q <= 1'b1;
            end
          end
          `SCPB_REG_EXTRA_N: begin
            nextra_q   <= (reg_wdata[2:0] > `SCPB_MAX_EXTRA) ? `SCPB_MAX_EXTRA : reg_wdata[2:0];
            pend_src_q <= 1'b1;
          end
          `SCPB_REG_PDO_V: begin
            // Duplicate voltages rejected: software must merge them into one entry
            if (scpb_entry_ok(reg_wdata) && !scpb_dup_volt(reg_wdata[9:0], reg_wdata[12:10])) begin
              pv_q[reg_wdata[12:10]] <= reg_wdata[9:0];
              pend_src_q <= 1'b1;
            end
          end
          `SCPB_REG_PDO_I: begin
            if (scpb_entry_ok(reg_wdata)) begin
              pi_q[reg_wdata[12:10]] <= reg_wdata[9:0];
              pend_src_q <= 1'b1;
            end
          end
          `SCPB_REG_PDO_PK: begin
            if (scpb_entry_ok(reg_wdata)) begin
              pk_q[reg_wdata[12:10]] <= reg_wdata[1:0];
              pend_src_q <= 1'b1;
            end
          end
          `SCPB_REG_PDO_SEL: sel_q <= reg_wdata[2:0];
          `SCPB_REG_RESERVE: begin
            if (!reg_wdata[16]) begin
              res_alloc_q <= 1'b0;
              res_loan_q  <= 1'b0;
              pend_src_q  <= 1'b1;
            end else begin
              res_loan_q <= reg_wdata[17];
            end
          end
          `SCPB_REG_BASE_I: begin
            base_i_q   <= reg_wdata[9:0];
            pend_src_q <= 1'b1;
          end
          default: ;
        endcase
      end
      if (rx_request) begin
        if (res_loan_q && rx_req_pos == sel_q + 3'h2 && req_res != 10'h000) begin
          tx_wait    <= 1'b1;
          tx_gotomin <= 1'b1;
        end else if (req_res != 10'h000) begin
          reserve_q   <= req_res;
          res_alloc_q <= 1'b1;
          res_loan_q  <= rx_req_giveback;
        end
      end
      if (ctrl_q[`SCPB_CTRL_SEND] || (ws && reg_addr == `SCPB_REG_CTRL && reg_wdata[`SCPB_CTRL_SEND]))
        pend_src_q <= 1'b1;
      if (rx_get_src_cap)
        pend_qry_q <= 1'b1;
      if (rx_get_snk_cap)
        pend_snk_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit sequencer
  always @(posedge clk) begin
    if (!nrst) begin
      st_q         <= ST_IDLE;
      idx_q        <= 3'h0;
      snk_q        <= 1'b0;
      tx_start     <= 1'b0;
      tx_msg_type  <= 4'h0;
      tx_nobj      <= 3'h0;
      tx_obj_valid <= 1'b0;
      tx_obj       <= 32'h0000_0000;
      tx_last      <= 1'b0;
    end else if (ce) begin
      tx_start <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          tx_obj_valid <= 1'b0;
          tx_last      <= 1'b0;
          if (take) begin
            snk_q <= pend_snk_q;
            st_q  <= ST_HDR;
          end
        end
        ST_HDR: begin
          tx_start    <= 1'b1;
          tx_msg_type <= snk_q ? `SCPB_MSG_SNK_CAP : `SCPB_MSG_SRC_CAP;
          tx_nobj     <= nsend;
          idx_q       <= 3'h0;
          st_q        <= ST_OBJ;
        end
        ST_OBJ: begin
          if (tx_ready || !tx_obj_valid) begin
            if (tx_obj_valid && tx_last) begin
              tx_obj_valid <= 1'b0;
              tx_last      <= 1'b0;
              st_q         <= ST_IDLE;
            end else begin
              tx_obj       <= obj_w;
              tx_obj_valid <= 1'b1;
              tx_last      <= (idx_q + 3'h1 == nsend);
              idx_q        <= idx_q + 3'h1;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Type-A back-power guard
  always @(posedge clk) begin
    if (!nrst) begin
      vbus_off   <= 1'b0;
      toff_run_q <= 1'b0;
      toff_cnt_q <= 32'h0000_0000;
    end else if (ce) begin
      // Cut well before the limit: act on the first cycle after EOP
      if (rx_src_cap_eop && !rx_src_cap_solicited && ctrl_q[`SCPB_CTRL_TYPEA] && ctrl_q[`SCPB_CTRL_SRC]) begin
        vbus_off   <= 1'b1;
        toff_run_q <= 1'b1;
        toff_cnt_q <= 32'h0000_0000;
      end else if (toff_run_q && toff_cnt_q < TOFF_CYC) begin
        toff_cnt_q <= toff_cnt_q + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads
  always @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `SCPB_REG_CTRL:    reg_rdata <= {26'h0, ctrl_q};
          `SCPB_REG_FLAGS:   reg_rdata <= {27'h0, flags_q};
          `SCPB_REG_EXTRA_N: reg_rdata <= {29'h0, nextra_q};
          `SCPB_REG_PDO_SEL: reg_rdata <= {29'h0, sel_q};
          `SCPB_REG_RESERVE: reg_rdata <= {14'h0, res_loan_q, res_alloc_q, 6'h0, reserve_q};
          `SCPB_REG_STATUS:  reg_rdata <= {24'h0, vbus_off, pend_snk_q, pend_src_q, idx_q, st_q};
          `SCPB_REG_BASE_I:  reg_rdata <= {22'h0, base_i_q};
          default:           reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // scpb_builder

// *** scpb_builder_chk.sv ***
// Port assertions for the capabilities builder
`timescale 1ns/1ps
module scpb_builder_chk #(parameter [4:0] FLAGS_STRAP = 5'h00) (
  // Clock and reset
  input wire        clk,
  input wire        nrst,
  // Transmit and policy outputs
  input wire        tx_start,
  input wire [3:0]  tx_msg_type,
  input wire [2:0]  tx_nobj,
  input wire        tx_obj_valid,
  input wire [31:0] tx_obj,
  input wire        tx_last,
  input wire        tx_ready,
  input wire        tx_wait,
  input wire        tx_gotomin,
  input wire        vbus_off
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  reg        first_q;
  reg  [2:0] cnt_q;
  reg  [2:0] nobj_q;
  wire       acc = tx_obj_valid & tx_ready;
  always @(posedge clk) begin
    if (!nrst || tx_start) begin
      first_q <= 1'b1;
      cnt_q   <= 3'h0;
      nobj_q  <= tx_nobj;
    end else if (acc) begin
      first_q <= 1'b0;
      cnt_q   <= cnt_q + 3'h1;
    end
  end
  a_fixed_type: assert property (tx_obj_valid |-> tx_obj[31:30] == 2'h0) else $error("type code");
  a_rsv_bits: assert property (tx_obj_valid |-> tx_obj[24:22] == 3'h0) else $error("reserved bits");
  a_first_safe: assert property (tx_obj_valid && first_q |-> tx_obj[19:10] == 10'h064) else $error("first");
  a_first_flags: assert property (tx_obj_valid && first_q && tx_msg_type == 4'h1
    |-> tx_obj[29:25] == FLAGS_STRAP) else $error("flags");
  a_other_zero: assert property (tx_obj_valid && !first_q |-> tx_obj[29:22] == 8'h00) else $error("bits");
  a_count_match: assert property (acc && tx_last |-> cnt_q + 3'h1 == nobj_q) else $error("count");
  a_snk_single: assert property (tx_start && tx_msg_type == 4'h4 |-> tx_nobj == 3'h1) else $error("snk");
  a_wait_pair: assert property (tx_wait |-> tx_gotomin ##1 !tx_wait) else $error("wait");
  a_vbus_sticky: assert property (vbus_off |=> vbus_off) else $error("vbus");
  a_obj_hold: assert property (tx_obj_valid && !tx_ready |=> tx_obj_valid && $stable(tx_obj))
    else $error("hold");
  c_src: cover property (tx_start && tx_msg_type == 4'h1);
  c_snk: cover property (tx_start && tx_msg_type == 4'h4);
  c_wait: cover property (tx_wait);
  c_voff: cover property ($rose(vbus_off));
endmodule // scpb_builder_chk
bind scpb_builder scpb_builder_chk #(.FLAGS_STRAP(FLAGS_STRAP)) u_chk (.clk(clk), .nrst(nrst),
  .tx_start(tx_start), .tx_msg_type(tx_msg_type), .tx_nobj(tx_nobj), .tx_obj_valid(tx_obj_valid),
  .tx_obj(tx_obj), .tx_last(tx_last), .tx_ready(tx_ready), .tx_wait(tx_wait),
  .tx_gotomin(tx_gotomin), .vbus_off(vbus_off));

// *** scpb_builder_tb.sv ***
// Self-checking bench for the capabilities builder
`timescale 1ns/1ps
module scpb_builder_tb;
  localparam [4:0] FL = 5'h15;
  reg         clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  reg  [3:0]  ra = 4'h0;
  reg  [31:0] wd = 32'h0, d, sd;
  reg         gsrc = 1'b0, gsnk = 1'b0, eop = 1'b0, sol = 1'b0, slow = 1'b0, gb = 1'b0;
  reg  [9:0]  op = 10'h064, mx = 10'h064, bi, v [0:5], c [0:5];
  reg  [1:0]  p [0:5];
  reg  [2:0]  pos = 3'h1;
  wire        rq, rgb, ts, tv, tl, trdy, twt, tgm, voff;
  wire [9:0]  rop, rmx;
  wire [2:0]  rpos, tn;
  wire [3:0]  tty;
  wire [31:0] rdat, tobj;
  integer     err_total = 0, total_checks = 0, ng = 0, nm = 0, nw = 0, j, k, n, s, m0, lp;
  reg  [31:0] got [0:7];
  reg  [3:0]  gty;
  scpb_builder #(.TOFF_CYC(16), .FLAGS_STRAP(FL)) DUT (.clk(clk), .nrst(nrst), .ce(1'b1),
    .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
    .rx_get_src_cap(gsrc), .rx_get_snk_cap(gsnk), .rx_src_cap_eop(eop), .rx_src_cap_solicited(sol),
    .rx_request(rq), .rx_req_op(rop), .rx_req_max(rmx), .rx_req_pos(rpos), .rx_req_giveback(rgb),
    .tx_start(ts), .tx_msg_type(tty), .tx_nobj(tn), .tx_obj_valid(tv), .tx_obj(tobj), .tx_last(tl),
    .tx_ready(trdy), .tx_wait(twt), .tx_gotomin(tgm), .vbus_off(voff));
  scpb_sink_model u_snk (.clk(clk), .nrst(nrst), .slow(slow), .op(op), .mx(mx), .pos(pos), .gb(gb),
    .tx_msg_type(tty), .tx_obj_valid(tv), .tx_last(tl), .tx_ready(trdy), .rx_request(rq),
    .rx_req_op(rop), .rx_req_max(rmx), .rx_req_pos(rpos), .rx_req_giveback(rgb));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    if (ts) ng = 0;
    if (ts) gty = tty;
    if (tv && trdy) begin
      got[ng[2:0]] = tobj;
      ng = ng + 1;
      nm = nm + (tl ? 1 : 0);
    end
    if (twt) nw = nw + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function [31:0] fx(input [1:0] pk, input [9:0] vv, input [9:0] ii);
    fx = {2'h0, 5'h00, 3'h0, pk, vv, ii};
  endfunction
  function [9:0] sat(input [9:0] a, input [9:0] b);
    sat = ({1'b0, a} + b > 11'h3FF) ? 10'h3FF : a + b;
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task w(input [3:0] a, input [31:0] dd);
    ra <= a;
    wd <= dd;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task r(input [3:0] a);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdat;
  endtask
  // Waits for the next whole message; a hang closes the run
  task wm(input [3:0] ty, input integer cnt);
    m0 = nm;
    k = 0;
    while (nm == m0 && k < 400) begin
      @(posedge clk);
      #1;
      k = k + 1;
    end
    if (k == 400) begin
      chk(32'h0, 32'h1);
      test_done;
    end
    chk(gty, ty);
    chk(ng, cnt);
  endtask
  // Stops adverts and lets any message in flight drain
  task quiet;
    w(4'h0, 32'h0);
    k = 0;
    d = 32'h1;
    while (d[1:0] != 2'h0 && k < 100) begin
      r(4'h8);
      k = k + 1;
    end
    if (k == 100) begin
      chk(32'h0, 32'h1);
      test_done;
    end
  endtask
  task pulse_eop(input so);
    sol <= so;
    eop <= 1'b1;
    @(posedge clk);
    eop <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Whole list compare, reserve added to the selected entry
  task cmp_list(input integer rs);
    chk(got[0], {2'h0, FL, 5'h00, 10'h064, bi});
    for (j = 0; j < n; j = j + 1)
      chk(got[j + 1], fx(p[j], v[j], j == s ? sat(c[j], rs) : c[j]));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sd = $urandom(32'h424f);
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    r(4'h1);
    chk(d[4:0], FL);
    w(4'h1, 32'h0);
    r(4'h1);
    chk(d[4:0], FL);
    r(4'hF);
    chk(d, 32'h0);
    bi = $urandom % 1024;
    w(4'h9, {22'h0, bi});
    for (j = 0; j < 6; j = j + 1) begin
      v[j] = 10'h064 + 10'h014 * (j + 1);
      c[j] = $urandom % 1024;
      p[j] = $urandom % 4;
      w(4'h3, {19'h0, j[2:0], v[j]});
      w(4'h4, {19'h0, j[2:0], c[j]});
      w(4'h5, {19'h0, j[2:0], 8'h00, p[j]});
    end
    s = -1;
    for (lp = 0; lp < 3; lp = lp + 1) begin
      n = (lp == 2) ? 7 : 1 + $urandom % 6;
      slow <= lp[0];
      quiet;
      w(4'h2, n);
      n = (n > 6) ? 6 : n;
      w(4'h0, 32'h11);
      wm(4'h1, n + 1);
      cmp_list(0);
    end
    w(4'h0, 32'h0);
    gsrc <= 1'b1;
    @(posedge clk);
    gsrc <= 1'b0;
    wm(4'h1, n + 1);
    gsnk <= 1'b1;
    @(posedge clk);
    gsnk <= 1'b0;
    wm(4'h4, 1);
    s = $urandom % 6;
    w(4'h6, s);
    pos <= s + 2;
    mx <= 10'h096;
    w(4'h0, 32'h11);
    wm(4'h1, n + 1);
    repeat (4) @(posedge clk);
    r(4'h7);
    chk(d[16:0], {1'b1, 16'd50});
    w(4'h0, 32'h11);
    wm(4'h1, n + 1);
    cmp_list(50);
    mx <= 10'h064;
    repeat (4) @(posedge clk);
    w(4'h7, 32'h0);
    wm(4'h1, n + 1);
    cmp_list(0);
    gb <= 1'b1;
    mx <= 10'h096;
    w(4'h7, 32'h30032);
    w(4'h0, 32'h11);
    wm(4'h1, n + 1);
    repeat (6) @(posedge clk);
    chk(nw > 0, 1);
    gb <= 1'b0;
    w(4'h0, 32'h21);
    wm(4'h1, n + 1);
    w(4'h0, 32'h13);
    wm(4'h1, n + 1);
    chk(got[0][19:0], {10'h064, 10'h000});
    w(4'h0, 32'h15);
    wm(4'h1, n + 1);
    chk(got[0][19:0], {10'h064, 10'h000});
    w(4'h0, 32'h9);
    pulse_eop(1'b1);
    chk(voff, 1'b0);
    pulse_eop(1'b0);
    chk(voff, 1'b1);
    test_done;
  end
endmodule // scpb_builder_tb

// *** scpb_consts.vh ***
// Constants for the source capabilities object builder
`ifndef SCPB_CONSTS_VH
`define SCPB_CONSTS_VH
// Register indices
`define SCPB_REG_CTRL      4'h0
`define SCPB_REG_FLAGS     4'h1
`define SCPB_REG_EXTRA_N   4'h2
`define SCPB_REG_PDO_V     4'h3
`define SCPB_REG_PDO_I     4'h4
`define SCPB_REG_PDO_PK    4'h5
`define SCPB_REG_PDO_SEL   4'h6
`define SCPB_REG_RESERVE   4'h7
`define SCPB_REG_STATUS    4'h8
`define SCPB_REG_BASE_I    4'h9
// CTRL bits
`define SCPB_CTRL_SRC      0
`define SCPB_CTRL_VCONN    1
`define SCPB_CTRL_NOCAP    2
`define SCPB_CTRL_TYPEA    3
`define SCPB_CTRL_SEND     4
`define SCPB_CTRL_GOTOMIN  5
// Object fields
`define SCPB_TYPE_FIXED    2'h0
`define SCPB_TYPE_MSB      31
`define SCPB_FLAG_MSB      29
`define SCPB_FLAG_LSB      25
`define SCPB_PEAK_MSB      21
`define SCPB_PEAK_LSB      20
`define SCPB_VOLT_MSB      19
`define SCPB_VOLT_LSB      10
`define SCPB_CURR_MSB      9
`define SCPB_CURR_LSB      0
`define SCPB_VSAFE5V_CODE  10'h064
`define SCPB_MAX_EXTRA     3'h6
`define SCPB_FLAGS_RESET   5'h00
// Message types
`define SCPB_MSG_SRC_CAP   4'h1
`define SCPB_MSG_SNK_CAP   4'h4
// Back-power removal
`define SCPB_TOFF_NS       650000000
`define SCPB_CLK_NS        20
`define SCPB_TOFF_CYC      (`SCPB_TOFF_NS / `SCPB_CLK_NS)
`endif

// *** scpb_sink_model.sv ***
// Sink engine model: transmit pacing and request replies
`timescale 1ns/1ps
module scpb_sink_model (
  // Clock and reset
  input  wire       clk,
  input  wire       nrst,
  // Reply setup from bench
  input  wire       slow,
  input  wire [9:0] op,
  input  wire [9:0] mx,
  input  wire [2:0] pos,
  input  wire       gb,
  // Builder transmit side
  input  wire [3:0] tx_msg_type,
  input  wire       tx_obj_valid,
  input  wire       tx_last,
  output reg        tx_ready        = 1'b0,
  // Request back to builder
  output reg        rx_request      = 1'b0,
  output reg  [9:0] rx_req_op       = 10'h000,
  output reg  [9:0] rx_req_max      = 10'h000,
  output reg  [2:0] rx_req_pos      = 3'h0,
  output reg        rx_req_giveback = 1'b0
);
  always @(posedge clk) begin
    tx_ready        <= !slow || ($urandom % 3 == 0);
    rx_request      <= 1'b0;
    // Released fields toggle so stale values never look valid
    rx_req_op       <= ~rx_req_op;
    rx_req_max      <= ~rx_req_max;
    rx_req_pos      <= ~rx_req_pos;
    rx_req_giveback <= ~rx_req_giveback;
    // Every advertisement answered, position within it
    // Reply never depends on the suspend flag
    if (nrst && tx_obj_valid && tx_ready && tx_last && tx_msg_type == 4'h1) begin
      rx_request      <= 1'b1;
      rx_req_op       <= op;
      rx_req_max      <= mx;
      rx_req_pos      <= pos;
      rx_req_giveback <= gb;
    end
  end
endmodule // scpb_sink_model
